// *** mlmsd_pkg.sv ***
// ----------------------------------------------------------------
// Shared constants of the Max-Log-MAP SISO decoder
// ----------------------------------------------------------------
package mlmsd_pkg;
  // Code shape: m-binary input, memory v, n coded values per stage
  localparam int M          = 2;
  localparam int V          = 3;
  localparam int NC         = 4;
  localparam int NS         = 1 << V;
  localparam int NSYM       = 1 << M;
  localparam int NLAB       = 1 << NC;
  // Default widths and frame length
  localparam int FRAME_LEN  = 64;
  localparam int SOFT_W     = 6;
  localparam int APRI_W     = 8;
  localparam int METRIC_W   = 12;
  // Extrinsic scale 0.7, approximated as 45/64
  localparam int SCALE_NUM  = 45;
  localparam int SCALE_SH   = 6;
  localparam int SCALE_W    = 8;
  // Processing phases, one-hot
  typedef enum logic [5:0] {
    PH_IDLE  = 6'h01,
    PH_LOAD  = 6'h02,
    PH_FWARM = 6'h04,
    PH_FWD   = 6'h08,
    PH_BWARM = 6'h10,
    PH_BOUT  = 6'h20
  } mlmsd_ph_e;
endpackage : mlmsd_pkg

// *** mlmsd_top.sv ***
`timescale 1ns/100ps
module mlmsd_top import mlmsd_pkg::*; #(
  parameter int NFRM = FRAME_LEN,
  parameter int SW   = SOFT_W,
  parameter int AW   = APRI_W,
  parameter int MW   = METRIC_W
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // Channel and a priori input stream
  input  wire logic                          in_valid,
  output logic                               in_ready,
  input  wire logic [NC-1:0][SW-1:0]         in_soft,
  input  wire logic [NSYM-1:0][AW-1:0]       in_apri,
  input  wire logic                          in_last_iter,
  // Soft output stream
  output logic                               out_valid,
  input  wire logic                          out_ready,
  output logic [$clog2(NFRM)-1:0]            out_idx,
  output logic [M-1:0]                       out_hard,
  output logic [NSYM-1:0][MW-1:0]            out_llr,
  output logic [NSYM-1:0][MW-1:0]            out_ext,
  // Status
  output logic                               busy
);
  localparam int KW = $clog2(NFRM);
  localparam logic [KW-1:0] K_LAST = KW'(NFRM - 1);
  localparam logic [KW-1:0] K_ONE  = KW'(1);
  typedef logic signed [MW-1:0] mt_t;
  typedef mt_t [3:0] mq_t;
  typedef struct packed {
    mlmsd_ph_e           ph;
    logic [KW-1:0]       k;
    logic                last;
    mt_t [NS-1:0]        alpha;
    mt_t [NS-1:0]        beta;
    logic                ov;
    logic [KW-1:0]       oidx;
    logic [M-1:0]        ohard;
    mt_t [NSYM-1:0]      ollr;
    mt_t [NSYM-1:0]      oext;
  } mlmsd_st_s;
  localparam mlmsd_st_s ST_RST = '{ph: PH_IDLE, default: '0};
  // ----------------------------------------------------------------
  // Trellis and min-tree functions
  // ----------------------------------------------------------------
  // Next state of the recursive register for symbol d
  function automatic logic [V-1:0] nxt_st(input logic [V-1:0] s, input logic [M-1:0] d);
    return {s[V-2:0] ^ {(V-1){d[M-1]}}, ^d ^ s[V-1] ^ s[0]};
  endfunction : nxt_st
  // Unique predecessor of state t under symbol d
  function automatic logic [V-1:0] pred_st(input logic [V-1:0] t, input logic [M-1:0] d);
    logic [V-1:0] s;
    s[V-2:0] = t[V-1:1] ^ {(V-1){d[M-1]}};
    s[V-1]   = t[0] ^ (^d) ^ s[0];
    return s;
  endfunction : pred_st
  // Parity labels, first parity bit in bit 0
  function automatic logic [NC-M-1:0] par_lab(input logic [V-1:0] s, input logic [M-1:0] d);
    return {^d ^ s[V-1] ^ s[0] ^ s[1], s[V-1] ^ d[0]};
  endfunction : par_lab
  // All four signed combinations of a pair, index {b2,b1}
  function automatic mq_t pair4(input logic signed [SW-1:0] a, input logic signed [SW-1:0] b);
    mt_t sp;
    mt_t sm;
    sp = mt_t'(a) + mt_t'(b);
    sm = mt_t'(a) - mt_t'(b);
    return {sp, -sm, sm, -sp};
  endfunction : pair4
  // Minimum over states through a compare-select tree
  function automatic mt_t min_st(input mt_t [NS-1:0] a);
    mt_t [NS-1:0] t;
    t = a;
    for (int w = NS / 2; w > 0; w = w / 2) begin
      for (int i = 0; i < w; i++) begin
        t[i] = (t[2*i+1] < t[2*i]) ? t[2*i+1] : t[2*i];
      end
    end
    return t[0];
  endfunction : min_st
  // Minimum over symbols with its index, {index, value}
  function automatic logic [M+MW-1:0] min_sym(input mt_t [NSYM-1:0] a);
    mt_t [NSYM-1:0]          t;
    logic [NSYM-1:0][M-1:0]  ix;
    t = a;
    for (int i = 0; i < NSYM; i++) ix[i] = M'(i);
    for (int w = NSYM / 2; w > 0; w = w / 2) begin
      for (int i = 0; i < w; i++) begin
        if (t[2*i+1] < t[2*i]) begin
          t[i]  = t[2*i+1];
          ix[i] = ix[2*i+1];
        end else begin
          t[i]  = t[2*i];
          ix[i] = ix[2*i];
        end
      end
    end
    return {ix[0], t[0]};
  endfunction : min_sym
  // ----------------------------------------------------------------
  // Reset release and frame memories
  // ----------------------------------------------------------------
  logic [1:0]                  rst_sync_r;
  logic                        rst_n_s, load_we, fwd_we;
  mlmsd_st_s                   st_r, st_nxt;
  logic [NC-1:0][SW-1:0]       soft_mem  [NFRM];
  logic [NSYM-1:0][AW-1:0]     apri_mem  [NFRM];
  mt_t [NS-1:0]                alpha_mem [NFRM];
  // Two-stage reset release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rst_sync_r <= 2'h0;
    else        rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n_s = rst_sync_r[1];
  // Frame input store and forward metric store
  always_ff @(posedge clk) begin
    if (load_we) begin
      soft_mem[st_r.k] <= in_soft;
      apri_mem[st_r.k] <= in_apri;
    end
    if (fwd_we) alpha_mem[st_r.k] <= st_r.alpha;
  end
  // ----------------------------------------------------------------
  // Stage datapath
  // ----------------------------------------------------------------
  logic [NC-1:0][SW-1:0]          cur_soft;
  logic [NSYM-1:0][AW-1:0]        cur_apri;
  mt_t [NS-1:0]                   cur_alpha, a_new, a_nrm, b_new, b_nrm;
  mq_t                            pr_sys, pr_par;
  mt_t [NLAB-1:0]                 full;
  mt_t [NS-1:0][NSYM-1:0]         bm, bme, fc, bb;
  mt_t [NSYM-1:0][NS-1:0]         lc, lce;
  mt_t [NSYM-1:0]                 lam, lame, llr, ext;
  logic [M+MW-1:0]                lsel;
  logic [M-1:0]                   hat;
  mt_t                            a_min, b_min;
  logic signed [MW+SCALE_W-1:0]   prod;
  assign cur_soft  = soft_mem[st_r.k];
  assign cur_apri  = apri_mem[st_r.k];
  assign cur_alpha = alpha_mem[st_r.k];
  // Systematic pair first, parity pair after it
  assign pr_sys = pair4(cur_soft[0], cur_soft[1]);
  assign pr_par = pair4(cur_soft[2], cur_soft[M+1]);
  // Last stage of the label tree: every n-value label
  for (genvar g = 0; g < NLAB; g++) begin : g_full
    assign full[g] = pr_sys[g % 4] + pr_par[g / 4];
  end
  // Branch, recursion and output arithmetic
  always_comb begin
    prod = '0; // Scaled extrinsic is only formed for undecided symbols
    for (int s = 0; s < NS; s++) begin
      for (int d = 0; d < NSYM; d++) begin
        // Symbol index d carries d_j in bit j-1; no noise variance enters
        bm[s][d]  = mt_t'($signed(cur_apri[d])) + mt_t'($signed(cur_apri[d]))
                    - full[{par_lab(V'(s), M'(d)), M'(d)}];
        bme[s][d] = -pr_par[par_lab(V'(s), M'(d))];
      end
    end
    for (int t = 0; t < NS; t++) begin
      for (int d = 0; d < NSYM; d++) begin
        fc[t][d] = st_r.alpha[pred_st(V'(t), M'(d))] + bm[pred_st(V'(t), M'(d))][d];
      end
      lsel     = min_sym(fc[t]);
      a_new[t] = lsel[MW-1:0];
    end
    for (int s = 0; s < NS; s++) begin
      for (int d = 0; d < NSYM; d++) begin
        bb[s][d] = bm[s][d] + st_r.beta[nxt_st(V'(s), M'(d))];
      end
      lsel     = min_sym(bb[s]);
      b_new[s] = lsel[MW-1:0];
    end
    a_min = min_st(a_new);
    b_min = min_st(b_new);
    for (int s = 0; s < NS; s++) begin
      a_nrm[s] = a_new[s] - a_min;
      b_nrm[s] = b_new[s] - b_min;
    end
    for (int d = 0; d < NSYM; d++) begin
      for (int s = 0; s < NS; s++) begin
        lc[d][s]  = cur_alpha[s] + bb[s][d];
        lce[d][s] = cur_alpha[s] + bme[s][d] + st_r.beta[nxt_st(V'(s), M'(d))];
      end
      lam[d]  = min_st(lc[d]);
      lame[d] = min_st(lce[d]);
    end
    lsel = min_sym(lam);
    hat  = lsel[M+MW-1:MW];
    for (int d = 0; d < NSYM; d++) begin
      if (M'(d) == hat) begin
        llr[d] = '0;
        ext[d] = '0;
      end else begin
        llr[d] = (lam[d] - lsel[MW-1:0]) >>> 1;
        prod   = (MW+SCALE_W)'(($signed(lame[d] - lame[hat])) >>> 1);
        if (!st_r.last) prod = (prod * (MW+SCALE_W)'(SCALE_NUM)) >>> SCALE_SH;
        ext[d] = prod[MW-1:0];
      end
    end
  end
  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt   = st_r;
    in_ready = (st_r.ph == PH_IDLE) || (st_r.ph == PH_LOAD);
    load_we  = in_valid && in_ready;
    fwd_we   = (st_r.ph == PH_FWD);
    if (st_r.ov && out_ready) st_nxt.ov = 1'b0;
    case (st_r.ph)
      PH_IDLE: begin
        if (in_valid) begin
          st_nxt.last = in_last_iter;
          st_nxt.k    = st_r.k + K_ONE;
          st_nxt.ph   = PH_LOAD;
        end
      end
      PH_LOAD: begin
        if (in_valid) begin
          st_nxt.k = st_r.k + K_ONE;
          if (st_r.k == K_LAST) begin
            st_nxt.k     = '0;
            st_nxt.alpha = '0;
            st_nxt.ph    = PH_FWARM;
          end
        end
      end
      PH_FWARM: begin
        // Warm-up pass: its end state seeds the stored pass
        st_nxt.alpha = a_nrm;
        st_nxt.k     = st_r.k + K_ONE;
        if (st_r.k == K_LAST) begin
          st_nxt.k  = '0;
          st_nxt.ph = PH_FWD;
        end
      end
      PH_FWD: begin
        st_nxt.alpha = a_nrm;
        st_nxt.k     = st_r.k + K_ONE;
        if (st_r.k == K_LAST) begin
          st_nxt.k    = K_LAST;
          st_nxt.beta = '0;
          st_nxt.ph   = PH_BWARM;
        end
      end
      PH_BWARM: begin
        // Warm-up pass: beta at stage zero stands in for stage N
        st_nxt.beta = b_nrm;
        st_nxt.k    = st_r.k - K_ONE;
        if (st_r.k == '0) begin
          st_nxt.k  = K_LAST;
          st_nxt.ph = PH_BOUT;
        end
      end
      PH_BOUT: begin
        if (!st_r.ov || out_ready) begin
          st_nxt.ov    = 1'b1;
          st_nxt.oidx  = st_r.k;
          st_nxt.ohard = hat;
          st_nxt.ollr  = llr;
          st_nxt.oext  = ext;
          st_nxt.beta  = b_nrm;
          st_nxt.k     = (st_r.k == '0) ? '0 : st_r.k - K_ONE; // Next frame loads from stage zero
          if (st_r.k == '0) st_nxt.ph = PH_IDLE;
        end
      end
      default: st_nxt = ST_RST;
    endcase
  end
  // State register
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) st_r <= ST_RST;
    else          st_r <= st_nxt;
  end
  // Outputs
  assign out_valid = st_r.ov;
  assign out_idx   = st_r.oidx;
  assign out_hard  = st_r.ohard;
  assign out_llr   = st_r.ollr;
  assign out_ext   = st_r.oext;
  assign busy      = (st_r.ph != PH_IDLE);
  // ----------------------------------------------------------------
  // Assertions and covers
  // ----------------------------------------------------------------
  logic trel_ok, llr_neg;
  always_comb begin
    trel_ok = 1'b1;
    llr_neg = 1'b0;
    for (int t = 0; t < NS; t++) begin
      for (int d = 0; d < NSYM; d++) begin
        if (nxt_st(pred_st(V'(t), M'(d)), M'(d)) != V'(t)) trel_ok = 1'b0;
      end
    end
    for (int d = 0; d < NSYM; d++) llr_neg = llr_neg | st_r.ollr[d][MW-1];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_s);
  trellis_bij_a: assert property (trel_ok) else $error("trellis not bijective");
  hard_zero_a: assert property (out_valid |-> out_llr[out_hard] == '0) else $error("hard llr nonzero");
  llr_sign_a: assert property (out_valid |-> !llr_neg) else $error("negative llr");
  ext_zero_a: assert property (out_valid |-> out_ext[out_hard] == '0) else $error("hard ext nonzero");
  alpha_norm_a: assert property ((st_r.ph == PH_FWD) |-> min_st(st_r.alpha) == '0)
    else $error("alpha not normalised");
  fwd_len_a: assert property ($rose(st_r.ph == PH_BWARM) |-> $past(st_r.k) == K_LAST
    && $past(st_r.ph) == PH_FWD) else $error("forward pass length");
  out_order_a: assert property (out_valid && out_ready |=> !out_valid
    || out_idx == $past(out_idx) - K_ONE) else $error("output order");
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_llr)
    && $stable(out_ext)) else $error("output dropped under stall");
  frame_done_c: cover property (out_valid && out_ready && out_idx == '0);
  stall_c: cover property (out_valid && !out_ready ##1 out_valid && out_ready);
  last_iter_c: cover property ((st_r.ph == PH_BOUT) && st_r.last);
endmodule : mlmsd_top

// *** mlmsd_partner.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Dual decoder side: takes the soft output stream, can stall
// ----------------------------------------------------------------
module mlmsd_partner import mlmsd_pkg::*; #(
  parameter int NFRM = 8
) (
  // Clock, reset and control
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          stall,
  input  wire logic                          clr,
  // Decoder output stream
  input  wire logic                          out_valid,
  output logic                               out_ready,
  input  wire logic [$clog2(NFRM)-1:0]       out_idx,
  input  wire logic [M-1:0]                  out_hard,
  input  wire logic [NSYM-1:0][METRIC_W-1:0] out_llr,
  input  wire logic [NSYM-1:0][METRIC_W-1:0] out_ext
);
  logic [$clog2(NFRM)-1:0]       seq  [NFRM];
  logic [M-1:0]                  hard [NFRM];
  logic [NSYM-1:0][METRIC_W-1:0] llr  [NFRM];
  logic [NSYM-1:0][METRIC_W-1:0] ext  [NFRM];
  int                            nbeat;

  // Accept beats, slowly when stalled, and file them by stage index
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_ready <= 1'b0;
      nbeat     <= 0;
    end else begin
      out_ready <= stall ? ~out_ready : 1'b1;
      if (clr) begin
        nbeat <= 0;
      end else if (out_valid && out_ready) begin
        if (nbeat < NFRM) begin
          seq[nbeat] <= out_idx;
        end
        hard[out_idx] <= out_hard;
        llr[out_idx]  <= out_llr;
        ext[out_idx]  <= out_ext;
        nbeat         <= nbeat + 1;
      end
    end
  end
endmodule : mlmsd_partner

// *** test_maxlog_map_siso_decoder.sv ***
`timescale 1ns/100ps
module test_maxlog_map_siso_decoder import mlmsd_pkg::*;;
  localparam int NFRM = 8;
  localparam int MW   = METRIC_W;
  localparam int SW   = SOFT_W;
  localparam int AW   = APRI_W;
  logic                     clk, rst_n, in_valid, in_ready, in_last_iter;
  logic                     out_valid, out_ready, busy, stall, clr;
  logic [NC-1:0][SW-1:0]    in_soft;
  logic [NSYM-1:0][AW-1:0]  in_apri;
  logic [$clog2(NFRM)-1:0]  out_idx;
  logic [M-1:0]             out_hard;
  logic [NSYM-1:0][MW-1:0]  out_llr, out_ext;
  logic [M-1:0]             sym [NFRM];
  logic [M-1:0]             exp_hard [NFRM];
  logic [2:0]               st0;
  int                       miscompares = 0;
  int                       check_count = 0;

  // Clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  mlmsd_top #(.NFRM(NFRM)) u_dut (.clk(clk), .rst_n(rst_n), .in_valid(in_valid), .in_ready(in_ready),
    .in_soft(in_soft), .in_apri(in_apri), .in_last_iter(in_last_iter), .out_valid(out_valid),
    .out_ready(out_ready), .out_idx(out_idx), .out_hard(out_hard), .out_llr(out_llr),
    .out_ext(out_ext), .busy(busy));

  mlmsd_partner #(.NFRM(NFRM)) u_partner (.clk(clk), .rst_n(rst_n), .stall(stall), .clr(clr),
    .out_valid(out_valid), .out_ready(out_ready), .out_idx(out_idx), .out_hard(out_hard),
    .out_llr(out_llr), .out_ext(out_ext));

  // ----------------------------------------------------------------
  // Reporting and helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done

  task automatic cmp_v(input string n, input logic [MW-1:0] e, input logic [MW-1:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %0h seen %0h", n, e, g);
    end
  endtask : cmp_v

  // Rounding of the scale may sit before or after the halving
  task automatic cmp_near(input string n, input logic [MW-1:0] e, input logic [MW-1:0] g);
    check_count++;
    if (g !== e && g !== e + 1'b1 && g !== e - 1'b1) begin
      miscompares++;
      $display("BAD %s expected %0h seen %0h", n, e, g);
    end
  endtask : cmp_near

  function automatic logic [2:0] nxt_st(input logic [2:0] s, input logic [M-1:0] d);
    return {s[1:0] ^ {2{d[1]}}, d[0] ^ d[1] ^ s[2] ^ s[0]};
  endfunction : nxt_st

  function automatic logic [SW-1:0] sv(input logic b);
    return b ? 6'h14 : 6'h2c;
  endfunction : sv

  // Pick a symbol pattern and the state that closes the circle on it
  task automatic find_circ();
    logic [2:0] s;
    logic       hit;
    hit = 1'b0;
    st0 = 3'h0;
    for (int k = 0; k < NFRM; k++) sym[k] = M'((3 * k + 1) % 4);
    for (int i = 0; i < 8; i++) begin
      s = 3'(i);
      for (int k = 0; k < NFRM; k++) s = nxt_st(s, sym[k]);
      if (s == 3'(i)) begin
        st0 = 3'(i);
        hit = 1'b1;
      end
    end
    if (!hit) for (int k = 0; k < NFRM; k++) sym[k] = 2'h0;
  endtask : find_circ

  task automatic wait_ready();
    for (int i = 0; i < 200; i++) begin
      @(negedge clk);
      if (in_ready === 1'b1) begin
        @(posedge clk);
        return;
      end
    end
    miscompares++;
    test_done();
  endtask : wait_ready

  // One frame back to back, then three beats that must be refused
  task automatic send_frame(input logic last, input logic pm);
    logic [2:0]              s;
    logic                    fb;
    logic [NSYM-1:0][AW-1:0] ap;
    s = st0;
    for (int k = 0; k < NFRM; k++) begin
      fb = sym[k][0] ^ sym[k][1] ^ s[2] ^ s[0];
      for (int d = 0; d < NSYM; d++) ap[d] = (pm && d != k % 4) ? 8'h14 : 8'h00;
      exp_hard[k] = pm ? M'(k % 4) : sym[k];
      in_soft      <= pm ? '0 : {sv(fb ^ s[1]), sv(s[2] ^ sym[k][0]), sv(sym[k][1]), sv(sym[k][0])};
      in_apri      <= ap;
      in_valid     <= 1'b1;
      in_last_iter <= last;
      @(posedge clk);
      s = nxt_st(s, sym[k]);
    end
    in_soft <= '1;
    repeat (3) @(posedge clk);
    in_valid <= 1'b0;
  endtask : send_frame

  task automatic run_frame(input logic last, input logic pm);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    wait_ready();
    send_frame(last, pm);
    for (int i = 0; i < 500; i++) begin
      @(negedge clk);
      if (u_partner.nbeat == NFRM && busy === 1'b0) break;
      if (i == 499) begin
        miscompares++;
        test_done();
      end
    end
    repeat (5) @(negedge clk);
    cmp_v("beats", MW'(NFRM), MW'(u_partner.nbeat));
    cmp_v("busy", '0, MW'(busy));
  endtask : run_frame

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic check_frame(input logic pm);
    logic [M-1:0]  h;
    logic [MW-1:0] v;
    for (int b = 0; b < NFRM; b++) cmp_v("idx", MW'(NFRM - 1 - b), MW'(u_partner.seq[b]));
    for (int k = 0; k < NFRM; k++) begin
      h = exp_hard[k];
      cmp_v("hard", MW'(h), MW'(u_partner.hard[k]));
      cmp_v("llr_min", '0, u_partner.llr[k][h]);
      cmp_v("ext_min", '0, u_partner.ext[k][h]);
      for (int d = 0; d < NSYM; d++) begin
        v = u_partner.llr[k][d];
        if (d != h && pm) cmp_v("llr", 12'h014, v);
        if (d != h && pm) cmp_v("ext", '0, u_partner.ext[k][d]);
        if (d != h && !pm) cmp_v("llr_pos", 12'h001, MW'(v[MW-1] === 1'b0 && v !== '0));
      end
    end
  endtask : check_frame

  task automatic scen_scale();
    logic [NSYM-1:0][MW-1:0] keep [NFRM];
    run_frame(1'b1, 1'b0);
    check_frame(1'b0);
    keep = u_partner.ext;
    stall <= 1'b1;
    run_frame(1'b0, 1'b0);
    stall <= 1'b0;
    check_frame(1'b0);
    for (int k = 0; k < NFRM; k++) begin
      for (int d = 0; d < NSYM; d++) begin
        cmp_near("ext_scaled", MW'((int'($signed(keep[k][d])) * SCALE_NUM) >>> SCALE_SH), u_partner.ext[k][d]);
      end
    end
  endtask : scen_scale

  task automatic scen_reset();
    wait_ready();
    in_valid <= 1'b1;
    repeat (3) @(posedge clk);
    rst_n    <= 1'b0;
    in_valid <= 1'b0;
    @(negedge clk);
    cmp_v("rst_busy", '0, MW'(busy));
    cmp_v("rst_valid", '0, MW'(out_valid));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    run_frame(1'b1, 1'b1);
    check_frame(1'b1);
  endtask : scen_reset

  // Main sequence
  initial begin
    rst_n        = 1'b0;
    in_valid     = 1'b0;
    in_soft      = '0;
    in_apri      = '0;
    in_last_iter = 1'b0;
    stall        = 1'b0;
    clr          = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    find_circ();
    run_frame(1'b1, 1'b1);
    check_frame(1'b1);
    scen_scale();
    scen_reset();
    test_done();
  end
endmodule : test_maxlog_map_siso_decoder
